/* design/core_config_fault_status_regs.sv */
// Configuration, cache identification and fault status registers.
`timescale 1ns/1ps
`include "core_regs_defines.svh"
module core_config_fault_status_regs (
	input  wire logic                    clock,
	input  wire logic                    reset,
	input  wire logic                    acc_valid,
	input  wire logic                    acc_write,
	input  wire logic [31:0]             acc_addr,
	input  wire core_regs_pkg::acc_size_t acc_size,
	input  wire logic [31:0]             acc_wdata,
	input  wire logic                    acc_priv,
	input  wire logic                    acc_nonsec,
	input  wire logic                    acc_debug,
	output logic                         acc_done,
	output logic [31:0]                  acc_rdata,
	output logic                         acc_fault,
	input  wire logic                    busfault_nonsecure_target,
	input  wire logic [3:0]              cache_selector_s,
	input  wire logic [3:0]              cache_selector_ns,
	input  wire logic                    cur_secure,
	input  wire logic                    exec_neg_prio,
	input  wire logic                    stack_viol,
	input  wire logic                    stack_viol_secure,
	input  wire logic                    precise_bus_err,
	input  wire logic                    div_zero_evt,
	input  wire logic                    unal_evt,
	input  wire logic                    unal_multi,
	input  wire logic                    trig_unpriv_wr,
	input  wire logic [31:0]             fault_set_s,
	input  wire logic [31:0]             fault_set_ns,
	output logic [1:0]                   branch_predict_enable,
	output logic [1:0]                   instr_cache_enable,
	output logic [1:0]                   data_cache_enable,
	output logic                         take_stack_fault,
	output logic                         take_bus_fault,
	output logic                         take_usage_fault,
	output logic                         trig_fault,
	output logic                         trig_permit
);
	import core_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Address decode and access checks.

	logic       hit_ctl;
	logic       hit_ctl_al;
	logic       hit_fs;
	logic       hit_fs_al;
	logic       hit_ci;
	logic       hit_ci_al;
	logic       hit_alias;
	logic       alias_ok;
	logic       priv_ok;
	logic       go;
	logic       blocked;
	logic       bk;
	logic       wr;
	logic       is_word;
	logic       ctl_wr;
	logic       fs_wr;
	logic       bus_hidden;
	logic [3:0] lanes;

	assign hit_ctl    = acc_addr == `ADDR_CFG_CTL;
	assign hit_ctl_al = acc_addr == `ADDR_CFG_CTL_NS;
	assign hit_ci     = acc_addr == `ADDR_CACHE_INFO;
	assign hit_ci_al  = acc_addr == `ADDR_CACHE_INF_NS;
	assign hit_fs     = (acc_addr & `ADDR_WORD_MASK) == `ADDR_FAULT_ST;
	assign hit_fs_al  = (acc_addr & `ADDR_WORD_MASK) == `ADDR_FAULT_ST_NS;
	assign hit_alias  = hit_ctl_al || hit_fs_al || hit_ci_al;
	// Aliases serve only Secure software; others see zero.
	assign alias_ok   = !acc_nonsec && !acc_debug;
	assign blocked    = hit_alias && !alias_ok;
	assign priv_ok    = acc_priv || acc_debug;
	assign go         = acc_valid && priv_ok;
	assign bk         = !acc_nonsec && !hit_alias;
	assign wr         = go && acc_write && !blocked;
	assign is_word    = acc_size == SIZE_WORD;
	// Sub-word writes to word-only registers are dropped.
	assign ctl_wr     = wr && is_word && (hit_ctl || hit_ctl_al);
	assign fs_wr      = wr && (hit_fs || hit_fs_al) && `CFG_MAIN_EXT;
	assign bus_hidden = !bk && !busfault_nonsecure_target;

	always_comb begin
		case (acc_size)
			SIZE_WORD: lanes = 4'hF;
			SIZE_HALF: lanes = acc_addr[1] ? 4'hC : 4'h3;
			SIZE_BYTE: lanes = 4'h1 << acc_addr[1:0];
			default:   lanes = 4'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Banked control bits.

	ctl_bank_t ctl_ff [2];
	ctl_bank_t nxt_bank;
	logic      bus_ign_ff;
	logic [1:0] bpred_eff;
	logic [1:0] unal_eff;

	always_comb begin
		nxt_bank        = ctl_ff[bk];
		nxt_bank.icache = acc_wdata[`BIT_ICACHE];
		if (`CFG_MAIN_EXT) begin
			if (`CFG_BPRED_MODE == `BPRED_SWITCHABLE) begin
				nxt_bank.bpred = acc_wdata[`BIT_BPRED];
			end
			nxt_bank.dcache  = acc_wdata[`BIT_DCACHE];
			nxt_bank.stk_ign = acc_wdata[`BIT_STK_IGN];
			nxt_bank.div0    = acc_wdata[`BIT_DIV0];
			nxt_bank.unal    = acc_wdata[`BIT_UNAL];
			nxt_bank.upend   = acc_wdata[`BIT_UPEND];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctl_ff[0] <= `CTL_BANK_RST;
			ctl_ff[1] <= `CTL_BANK_RST;
		end else if (ctl_wr) begin
			ctl_ff[bk] <= nxt_bank;
		end
	end

	// Non-secure may not change it while bus faults stay Secure.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bus_ign_ff <= 1'h0;
		end else if (ctl_wr && `CFG_MAIN_EXT &&
			(bk || busfault_nonsecure_target)) begin
			bus_ign_ff <= acc_wdata[`BIT_BUS_IGN];
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (!`CFG_MAIN_EXT) begin
				bpred_eff[i] = 1'h0;
			end else if (`CFG_BPRED_MODE == `BPRED_ALWAYS_ON) begin
				bpred_eff[i] = 1'h1;
			end else if (`CFG_BPRED_MODE == `BPRED_SWITCHABLE) begin
				bpred_eff[i] = ctl_ff[i].bpred;
			end else begin
				bpred_eff[i] = 1'h0;
			end
			// Without the Main Extension the trap is hardwired on.
			unal_eff[i] = `CFG_MAIN_EXT ? ctl_ff[i].unal : 1'h1;
			branch_predict_enable[i] = bpred_eff[i];
			instr_cache_enable[i]    = ctl_ff[i].icache;
			data_cache_enable[i]     = ctl_ff[i].dcache;
		end
	end

	function automatic logic [31:0] ctl_word(input logic b);
		logic [31:0] w;
		w               = 32'h0000_0000;
		w[`BIT_BPRED]   = bpred_eff[b];
		w[`BIT_ICACHE]  = ctl_ff[b].icache;
		w[`BIT_DCACHE]  = ctl_ff[b].dcache;
		w[`BIT_STK_IGN] = ctl_ff[b].stk_ign;
		w[`BIT_RES1_HI] = 1'h1;
		w[`BIT_BUS_IGN] = bus_ign_ff;
		w[`BIT_DIV0]    = ctl_ff[b].div0;
		w[`BIT_UNAL]    = unal_eff[b];
		w[`BIT_UPEND]   = ctl_ff[b].upend;
		w[`BIT_RES1_LO] = 1'h1;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Fault qualification.

	logic        div_hit;
	logic        unal_hit;
	logic        bus_take;
	logic [15:0] usage_evt;
	logic        stk_ff;
	logic        bus_ff;
	logic        usage_ff;
	logic        trig_fault_ff;
	logic        trig_permit_ff;

	assign div_hit  = div_zero_evt && ctl_ff[cur_secure].div0;
	assign unal_hit = unal_evt &&
		(unal_multi || unal_eff[cur_secure]);
	assign bus_take = precise_bus_err && !(exec_neg_prio && bus_ign_ff);

	always_comb begin
		usage_evt              = 16'h0000;
		usage_evt[`USAGE_DIVZ] = div_hit;
		usage_evt[`USAGE_UNAL] = unal_hit;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stk_ff   <= 1'h0;
			bus_ff   <= 1'h0;
			usage_ff <= 1'h0;
		end else begin
			stk_ff   <= stack_viol && !(exec_neg_prio &&
				ctl_ff[stack_viol_secure].stk_ign);
			bus_ff   <= bus_take;
			usage_ff <= div_hit || unal_hit;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			trig_fault_ff  <= 1'h0;
			trig_permit_ff <= 1'h0;
		end else begin
			trig_fault_ff  <= trig_unpriv_wr && !ctl_ff[cur_secure].upend;
			trig_permit_ff <= trig_unpriv_wr && ctl_ff[cur_secure].upend;
		end
	end

	assign take_stack_fault = stk_ff;
	assign take_bus_fault   = bus_ff;
	assign take_usage_fault = usage_ff;
	assign trig_fault       = trig_fault_ff;
	assign trig_permit      = trig_permit_ff;

	////////////////////////////////////////////////////////////////////////
	// Fault status fields.

	logic [31:0] clr_word;
	flag_bank_if #(.WIDTH(16)) us_s ();
	flag_bank_if #(.WIDTH(16)) us_ns ();
	flag_bank_if #(.WIDTH(8))  bs ();
	flag_bank_if #(.WIDTH(8))  mm_s ();
	flag_bank_if #(.WIDTH(8))  mm_ns ();

	assign clr_word = fs_wr ? (acc_wdata & {{8{lanes[3]}}, {8{lanes[2]}},
		{8{lanes[1]}}, {8{lanes[0]}}}) : 32'h0000_0000;

	always_comb begin
		us_s.set  = fault_set_s[31:16] | (cur_secure ? usage_evt : 16'h0000);
		us_ns.set = fault_set_ns[31:16] | (cur_secure ? 16'h0000 : usage_evt);
		bs.set    = fault_set_s[15:8] | fault_set_ns[15:8];
		bs.set[`BUS_PRECISE] = bs.set[`BUS_PRECISE] | bus_take;
		mm_s.set  = fault_set_s[7:0];
		mm_ns.set = fault_set_ns[7:0];
		us_s.clr  = bk ? clr_word[31:16] : 16'h0000;
		us_ns.clr = bk ? 16'h0000 : clr_word[31:16];
		bs.clr    = bus_hidden ? 8'h00 : clr_word[15:8];
		mm_s.clr  = bk ? clr_word[7:0] : 8'h00;
		mm_ns.clr = bk ? 8'h00 : clr_word[7:0];
	end

	fault_flag_bank #(.WIDTH(16)) u_usage_s (
		.clock (clock),
		.reset (reset),
		.fb    (us_s)
	);
	fault_flag_bank #(.WIDTH(16)) u_usage_ns (
		.clock (clock),
		.reset (reset),
		.fb    (us_ns)
	);
	fault_flag_bank #(.WIDTH(8)) u_bus (
		.clock (clock),
		.reset (reset),
		.fb    (bs)
	);
	fault_flag_bank #(.WIDTH(8)) u_mm_s (
		.clock (clock),
		.reset (reset),
		.fb    (mm_s)
	);
	fault_flag_bank #(.WIDTH(8)) u_mm_ns (
		.clock (clock),
		.reset (reset),
		.fb    (mm_ns)
	);

	////////////////////////////////////////////////////////////////////////
	// Read path and response.

	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;
	logic        done_ff;
	logic        fault_ff;
	logic [3:0]  sel;

	assign sel = bk ? cache_selector_s : cache_selector_ns;

	// An unimplemented selection reads zero instead of an unknown value.
	function automatic logic [31:0] cache_word(input logic [3:0] s);
		case (s)
			`SEL_DATA_L1:  return {`CI_D_CAPS, `CI_D_SETS,
				`CI_D_WAYS, `CI_D_LINE};
			`SEL_INSTR_L1: return {`CI_I_CAPS, `CI_I_SETS,
				`CI_I_WAYS, `CI_I_LINE};
			default:       return 32'h0000_0000;
		endcase
	endfunction

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (go && !acc_write && !blocked) begin
			if (hit_ctl || hit_ctl_al) begin
				nxt_rdata = ctl_word(bk);
			end else if (hit_ci || hit_ci_al) begin
				nxt_rdata = cache_word(sel);
			end else if ((hit_fs || hit_fs_al) && `CFG_MAIN_EXT) begin
				nxt_rdata = {bk ? us_s.flags : us_ns.flags,
					bus_hidden ? 8'h00 : bs.flags,
					bk ? mm_s.flags : mm_ns.flags};
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_ff <= 32'h0000_0000;
			done_ff  <= 1'h0;
			fault_ff <= 1'h0;
		end else begin
			rdata_ff <= nxt_rdata;
			done_ff  <= acc_valid;
			fault_ff <= acc_valid && !priv_ok;
		end
	end

	assign acc_rdata = rdata_ff;
	assign acc_done  = done_ff;
	assign acc_fault = fault_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	bpred_write_a: assert property (
		(`CFG_BPRED_MODE == `BPRED_SWITCHABLE) && `CFG_MAIN_EXT && go &&
		acc_write && hit_ctl && is_word && !acc_nonsec
		|=> branch_predict_enable[1] == $past(acc_wdata[`BIT_BPRED]))
		else $error("prediction enable did not follow write");
	bpred_fixed_a: assert property (
		(`CFG_BPRED_MODE == `BPRED_ALWAYS_ON) && `CFG_MAIN_EXT
		|-> branch_predict_enable == 2'h3)
		else $error("fixed prediction not reading one");
	bus_ign_ro_a: assert property (
		go && acc_write && acc_nonsec && hit_ctl &&
		!busfault_nonsecure_target |=> $stable(bus_ign_ff))
		else $error("non-secure changed bus fault ignore");
	div_off_a: assert property (
		div_zero_evt && !unal_evt && !ctl_ff[cur_secure].div0
		|=> !take_usage_fault)
		else $error("divide fault raised while disabled");
	unal_multi_a: assert property (
		unal_evt && unal_multi |=> take_usage_fault)
		else $error("unaligned multiple did not fault");
	stk_ign_a: assert property (
		stack_viol && exec_neg_prio && ctl_ff[stack_viol_secure].stk_ign
		|=> !take_stack_fault)
		else $error("stack fault not ignored");
	alias_raz_a: assert property (
		acc_valid && !acc_write && hit_ci_al && acc_nonsec
		|=> acc_done && acc_rdata == 32'h0000_0000)
		else $error("alias visible to non-secure");
	cache_info_a: assert property (
		go && !acc_write && hit_ci && !acc_nonsec &&
		cache_selector_s == `SEL_DATA_L1
		|=> acc_rdata == {`CI_D_CAPS, `CI_D_SETS, `CI_D_WAYS, `CI_D_LINE})
		else $error("cache size word wrong");
	unpriv_a: assert property (
		acc_valid && !acc_priv && !acc_debug
		|=> acc_fault && acc_rdata == 32'h0000_0000)
		else $error("unprivileged access not faulted");
	w1c_all_a: assert property (
		fs_wr && bk && acc_wdata == 32'hFFFF_FFFF && is_word &&
		fault_set_s == 32'h0000_0000 && !div_hit && !unal_hit
		##1 fault_set_s == 32'h0000_0000 |-> us_s.flags == 16'h0000)
		else $error("usage status not cleared");

	ctl_write_c: cover property (ctl_wr && bk);
	fs_clear_c:  cover property (fs_wr && lanes == 4'h2);
	usage_c:     cover property (take_usage_fault ##1 acc_done);
	alias_c:     cover property (go && hit_ci_al && alias_ok);
endmodule // core_config_fault_status_regs

/* shared/core_regs_defines.svh */
// Offsets, field positions, reset values and build options of the core registers.
// Functional notes
// - Branch prediction per Security state runs only while its banked enable is set.
// - Fixed-on prediction reads one, absent prediction reads zero; writes ignored.
// - Instruction cache enable is a global enable, one copy per Security state.
// - Data cache enable per state governs Normal memory caching of that state.
// - Banked stack limit ignore drops stack violations at negative priority.
// - Unbanked bus fault ignore drops precise bus faults at negative priority.
// - Bus fault ignore is read-only to Non-secure while bus fault target is 0.
// - Banked divide trap enable turns division by zero into a usage fault.
// - Banked unaligned trap enable makes any unaligned access a usage fault.
// - Unaligned multiple, atomic and exclusive accesses always fault.
// - Without Main Extension unaligned trap reads one; otherwise resets zero.
// - Banked pend permit decides if unprivileged trigger writes fault.
// - All implemented control bits reset to zero on warm reset.
// - Cache size register is read-only at its direct address, banked.
// - Secure reaches the Non-secure cache size copy by alias; others read zero.
// - Cache size register describes the cache named by the selector.
// - Bits 31 to 28 report write-through, write-back, read and write allocate.
// - Set count at 27:13 and way count at 12:3 hold value minus one.
// - Line size code at 2:0 holds log2 of words per line minus two.
// - Fault status register is write-one-to-clear, word, half and byte access.
// - Fault status holds usage at 31:16, bus at 15:8, memory at 7:0.
`ifndef CORE_REGS_DEFINES_SVH
`define CORE_REGS_DEFINES_SVH

`define ADDR_CFG_CTL      32'hE000_ED14
`define ADDR_CFG_CTL_NS   32'hE002_ED14
`define ADDR_FAULT_ST     32'hE000_ED28
`define ADDR_FAULT_ST_NS  32'hE002_ED28
`define ADDR_CACHE_INFO   32'hE000_ED80
`define ADDR_CACHE_INF_NS 32'hE002_ED80
`define ADDR_WORD_MASK    32'hFFFF_FFFC

`define CFG_MAIN_EXT      1'h1
`define CFG_BPRED_MODE    2'h0
`define BPRED_SWITCHABLE  2'h0
`define BPRED_ALWAYS_ON   2'h1

`define BIT_BPRED         18
`define BIT_ICACHE        17
`define BIT_DCACHE        16
`define BIT_STK_IGN       10
`define BIT_RES1_HI       9
`define BIT_BUS_IGN       8
`define BIT_DIV0          4
`define BIT_UNAL          3
`define BIT_UPEND         1
`define BIT_RES1_LO       0
`define CTL_BANK_RST      7'h00
`define UNAL_RST          (~`CFG_MAIN_EXT)

`define USAGE_DIVZ        9
`define USAGE_UNAL        8
`define BUS_PRECISE       1

`define CI_D_CAPS         4'hF
`define CI_D_SETS         15'h007F
`define CI_D_WAYS         10'h003
`define CI_D_LINE         3'h1
`define CI_I_CAPS         4'h2
`define CI_I_SETS         15'h00FF
`define CI_I_WAYS         10'h001
`define CI_I_LINE         3'h1
`define SEL_DATA_L1       4'h0
`define SEL_INSTR_L1      4'h1

`endif

/* shared/core_regs_pkg.sv */
// Types shared by the core register bank.
package core_regs_pkg;
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_HALF = 2'h1,
		SIZE_WORD = 2'h2
	} acc_size_t;

	typedef struct packed {
		logic bpred;
		logic icache;
		logic dcache;
		logic stk_ign;
		logic div0;
		logic unal;
		logic upend;
	} ctl_bank_t;
endpackage

/* shared/flag_bank_if.sv */
// Set, clear and state of one sticky status field.
`timescale 1ns/1ps
interface flag_bank_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] set;
	logic [WIDTH-1:0] clr;
	logic [WIDTH-1:0] flags;
	modport owner(output set, output clr, input flags);
	modport bank(input set, input clr, output flags);
endinterface

/* design/fault_flag_bank.sv */
// Sticky status field with write-one-to-clear.
`timescale 1ns/1ps
module fault_flag_bank #(parameter int WIDTH = 8) (
	input wire logic   clock,
	input wire logic   reset,
	flag_bank_if.bank  fb
);
	logic [WIDTH-1:0] flags_ff;

	// A set in the clearing cycle wins so no event is lost.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= fb.set | (flags_ff & ~fb.clr);
		end
	end

	assign fb.flags = flags_ff;

	set_wins_a: assert property (@(posedge clock) disable iff (reset)
		(fb.set != '0) |=> ((flags_ff & $past(fb.set)) == $past(fb.set)))
		else $error("status set lost");
	w1c_keep_a: assert property (@(posedge clock) disable iff (reset)
		1'b1 |=> ((flags_ff & ~$past(fb.clr)) ==
		((($past(flags_ff)) | $past(fb.set)) & ~$past(fb.clr))))
		else $error("status bit changed without cause");
endmodule // fault_flag_bank

/* bench/tb_top.sv */
// Self-checking bench for the configuration and fault status registers.
`timescale 1ns/1ps
`include "core_regs_defines.svh"
module tb_top;
	import core_regs_pkg::*;
	logic        clock;
	logic        reset;
	logic        acc_valid;
	logic        acc_write;
	logic [31:0] acc_addr;
	acc_size_t   acc_size;
	logic [31:0] acc_wdata;
	logic        acc_priv;
	logic        acc_nonsec;
	logic        acc_debug;
	logic        acc_done;
	logic [31:0] acc_rdata;
	logic        acc_fault;
	logic        bf_target;
	logic [3:0]  sel_s;
	logic [3:0]  sel_ns;
	logic        cur_secure;
	logic        neg_prio;
	logic        stk_sec;
	logic        unal_multi;
	logic [31:0] fault_set_s;
	logic [4:0]  ev;
	logic [1:0]  pred_en;
	logic [1:0]  icen;
	logic [1:0]  dcen;
	logic [4:0]  tk;
	logic [31:0] rd;
	logic        fl;
	int          fails;
	int          checks_done;
	int          cycles;

	////////////////////////////////////////////////////////////////////////
	core_config_fault_status_regs dut (
		.clock(clock), .reset(reset), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_addr(acc_addr), .acc_size(acc_size),
		.acc_wdata(acc_wdata), .acc_priv(acc_priv), .acc_nonsec(acc_nonsec),
		.acc_debug(acc_debug), .acc_done(acc_done), .acc_rdata(acc_rdata),
		.acc_fault(acc_fault), .busfault_nonsecure_target(bf_target),
		.cache_selector_s(sel_s), .cache_selector_ns(sel_ns),
		.cur_secure(cur_secure), .exec_neg_prio(neg_prio),
		.stack_viol(ev[0]), .stack_viol_secure(stk_sec),
		.precise_bus_err(ev[1]), .div_zero_evt(ev[2]), .unal_evt(ev[3]),
		.unal_multi(unal_multi), .trig_unpriv_wr(ev[4]),
		.fault_set_s(fault_set_s), .fault_set_ns(32'h0000_0000),
		.branch_predict_enable(pred_en), .instr_cache_enable(icen),
		.data_cache_enable(dcen), .take_stack_fault(tk[4]),
		.take_bus_fault(tk[3]), .take_usage_fault(tk[2]),
		.trig_fault(tk[1]), .trig_permit(tk[0])
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// The answer stands for one cycle only, so it is taken just after the
	// edge that launches it and never a cycle later.
	task automatic acc(input logic [31:0] a, input logic [31:0] d = 32'h0,
		input logic w = 1'h0, input logic ns = 1'h0, input logic pr = 1'h1,
		input logic dbg = 1'h0, input acc_size_t sz = SIZE_WORD);
		@(posedge clock);
		acc_valid  <= 1'h1;
		acc_write  <= w;
		acc_addr   <= a;
		acc_wdata  <= d;
		acc_size   <= sz;
		acc_nonsec <= ns;
		acc_priv   <= pr;
		acc_debug  <= dbg;
		@(posedge clock);
		acc_valid <= 1'h0;
		#1;
		chk({31'h0, acc_done}, 32'h0000_0001);
		rd = acc_rdata;
		fl = acc_fault;
	endtask

	task automatic fire(input int i, input logic [4:0] exp);
		@(posedge clock);
		ev[i] <= 1'h1;
		@(posedge clock);
		ev <= 5'h00;
		#1;
		chk({27'h0, tk}, {27'h0, exp});
	endtask

	task automatic lvl(input logic [3:0] v);
		@(posedge clock);
		{cur_secure, neg_prio, stk_sec, unal_multi} <= v;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		acc(`ADDR_CFG_CTL);
		chk(rd, 32'h0000_0201 | {28'h0, `UNAL_RST, 3'h0});
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0000_0000);
		chk({26'h0, pred_en, icen, dcen}, 32'h0000_0000);
		acc(32'hE000_ED00);
		chk({rd[30:0], fl}, 32'h0000_0000);
		$display("reset values done");
	endtask

	task automatic t_ctl();
		acc(`ADDR_CFG_CTL, 32'h0007_051A, 1'h1);
		acc(`ADDR_CFG_CTL);
		chk(rd, 32'h0007_071B);
		chk({26'h0, pred_en, icen, dcen}, 32'h0000_002A);
		// The shared bus ignore bit must survive this write from Non-secure.
		acc(`ADDR_CFG_CTL, 32'h0005_0000, 1'h1, 1'h1);
		acc(`ADDR_CFG_CTL, 32'h0, 1'h0, 1'h1);
		chk(rd, 32'h0005_0301);
		chk({26'h0, pred_en, icen, dcen}, 32'h0000_003B);
		acc(`ADDR_CFG_CTL, 32'h0000_0000, 1'h1, 1'h0, 1'h0);
		chk({31'h0, fl}, 32'h0000_0001);
		acc(`ADDR_CFG_CTL);
		chk(rd, 32'h0007_071B);
		$display("control register done");
	endtask

	task automatic t_usage();
		lvl(4'h8);
		fire(2, 5'h04);
		lvl(4'h0);
		fire(2, 5'h00);
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0200_0000);
		acc(`ADDR_FAULT_ST, 32'h0100_0000, 1'h1);
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0200_0000);
		acc(`ADDR_FAULT_ST, 32'h0200_0000, 1'h1);
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0000_0000);
		lvl(4'h8);
		fire(3, 5'h04);
		lvl(4'h0);
		fire(3, 5'h00);
		lvl(4'h1);
		fire(3, 5'h04);
		acc(`ADDR_FAULT_ST, 32'h0, 1'h0, 1'h1);
		chk(rd, 32'h0100_0000);
		$display("usage faults done");
	endtask

	task automatic t_misc();
		lvl(4'h6);
		fire(0, 5'h00);
		lvl(4'h4);
		fire(0, 5'h10);
		fire(1, 5'h00);
		lvl(4'h0);
		fire(1, 5'h08);
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0100_0200);
		acc(`ADDR_FAULT_ST + 32'h1, 32'h0000_0200, 1'h1, 1'h0, 1'h1, 1'h0,
			SIZE_BYTE);
		acc(`ADDR_FAULT_ST + 32'h2, 32'h0100_0000, 1'h1, 1'h0, 1'h1, 1'h0,
			SIZE_HALF);
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0000_0000);
		@(posedge clock);
		fault_set_s <= 32'h0000_0081;
		@(posedge clock);
		fault_set_s <= 32'h0000_0000;
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0000_0081);
		acc(`ADDR_FAULT_ST, 32'h0000_0001, 1'h1, 1'h0, 1'h1, 1'h0, SIZE_BYTE);
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0000_0080);
		acc(`ADDR_FAULT_ST, 32'hFFFF_FFFF, 1'h1);
		acc(`ADDR_FAULT_ST);
		chk(rd, 32'h0000_0000);
		lvl(4'h8);
		fire(4, 5'h01);
		lvl(4'h0);
		fire(4, 5'h02);
		// Once bus faults are handed to Non-secure, it may clear the ignore.
		@(posedge clock);
		bf_target <= 1'h1;
		acc(`ADDR_CFG_CTL, 32'h0005_0000, 1'h1, 1'h1);
		acc(`ADDR_CFG_CTL, 32'h0, 1'h0, 1'h1);
		chk(rd, 32'h0005_0201);
		$display("stack, bus and trigger done");
	endtask

	task automatic t_cache();
		logic [31:0] cd;
		logic [31:0] ci;
		cd = {`CI_D_CAPS, `CI_D_SETS, `CI_D_WAYS, `CI_D_LINE};
		ci = {`CI_I_CAPS, `CI_I_SETS, `CI_I_WAYS, `CI_I_LINE};
		acc(`ADDR_CACHE_INFO);
		chk(rd, cd);
		acc(`ADDR_CACHE_INFO, 32'h0, 1'h0, 1'h1);
		chk(rd, ci);
		acc(`ADDR_CACHE_INF_NS);
		chk(rd, ci);
		acc(`ADDR_CACHE_INF_NS, 32'h0, 1'h0, 1'h1);
		chk(rd, 32'h0000_0000);
		acc(`ADDR_CACHE_INF_NS, 32'h0, 1'h0, 1'h0, 1'h1, 1'h1);
		chk(rd, 32'h0000_0000);
		acc(`ADDR_CACHE_INFO, 32'hFFFF_FFFF, 1'h1);
		acc(`ADDR_CACHE_INFO, 32'h0, 1'h0, 1'h0, 1'h0);
		chk({31'h0, fl}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		@(posedge clock);
		sel_s <= `SEL_INSTR_L1;
		acc(`ADDR_CACHE_INFO);
		chk(rd, ci);
		$display("cache identification done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	initial begin
		reset = 1'h1;
		{acc_valid, acc_write, acc_nonsec, acc_debug} = 4'h0;
		acc_priv = 1'h1;
		acc_addr = 32'h0000_0000;
		acc_wdata = 32'h0000_0000;
		acc_size = SIZE_WORD;
		bf_target = 1'h0;
		sel_s = `SEL_DATA_L1;
		sel_ns = `SEL_INSTR_L1;
		{cur_secure, neg_prio, stk_sec, unal_multi} = 4'h0;
		fault_set_s = 32'h0000_0000;
		ev = 5'h00;
		fails = 0;
		checks_done = 0;
		cycles = 0;
		repeat (6) @(posedge clock);
		reset <= 1'h0;
		t_reset();
		t_ctl();
		t_usage();
		t_misc();
		t_cache();
		close_out();
	end

	// A hung handshake would otherwise stall the run with no verdict.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			$display("[ERR] %0t cycle limit reached", $time);
			close_out();
		end
	end
endmodule // tb_top
